// File: include/fcq_pkg.sv
// Constants, types and state layout of the flash-card query block.
// Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
package fcq_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] FCQ_A_DATA = 8'h00;
	localparam logic [7:0] FCQ_A_ERR = 8'h04;
	localparam logic [7:0] FCQ_A_CNT = 8'h08;
	localparam logic [7:0] FCQ_A_SEC = 8'h0C;
	localparam logic [7:0] FCQ_A_CYL_L = 8'h10;
	localparam logic [7:0] FCQ_A_CYL_H = 8'h14;
	localparam logic [7:0] FCQ_A_DH = 8'h18;
	localparam logic [7:0] FCQ_A_STAT = 8'h1C;
	localparam logic [7:0] FCQ_A_CMD = 8'h20;
	localparam logic [7:0] FCQ_A_PARAM = 8'h24;
	localparam logic [7:0] FCQ_A_IRQ_ST = 8'h28;
	localparam logic [7:0] FCQ_A_IRQ_MK = 8'h2C;
	localparam logic [7:0] FCQ_A_CTRL = 8'h30;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FCQ_ST_BUSY = 7;
	localparam int FCQ_ST_READY = 6;
	localparam int FCQ_ST_FAULT = 5;
	localparam int FCQ_ST_DRQ = 3;
	localparam int FCQ_ST_ERRS = 0;
	localparam int FCQ_ERR_COMMAND_ABORTED_BIT = 2;
	localparam int FCQ_DH_LIN = 6;
	localparam int FCQ_IRQ_DONE = 0;
	localparam int FCQ_IRQ_DRQ = 1;
	localparam int FCQ_CTRL_EN = 0;

	// ----------------------------------------------------------------
	// Command and code values
	// ----------------------------------------------------------------
	localparam logic [7:0] FCQ_CMD_ERRQ = 8'h03;
	localparam logic [7:0] FCQ_CMD_SECQ = 8'h87;
	localparam logic [7:0] FCQ_EXT_NONE = 8'h00;
	localparam logic [7:0] FCQ_EXT_BADCMD = 8'h20;
	localparam logic [7:0] FCQ_EXT_BADADDR = 8'h21;
	localparam logic [7:0] FCQ_COMMAND_ABORTED_BIT_VAL = 8'h04;
	localparam logic [7:0] FCQ_ERASED_VAL = 8'hFF;
	localparam logic FCQ_CTRL_EN_RST = 1'b1;

	// ----------------------------------------------------------------
	// Information table byte offsets
	// ----------------------------------------------------------------
	localparam logic [8:0] FCQ_T_CYL_H = 9'h000;
	localparam logic [8:0] FCQ_T_CYL_L = 9'h001;
	localparam logic [8:0] FCQ_T_HEAD = 9'h002;
	localparam logic [8:0] FCQ_T_SEC = 9'h003;
	localparam logic [8:0] FCQ_T_LBA_H = 9'h004;
	localparam logic [8:0] FCQ_T_LBA_M = 9'h005;
	localparam logic [8:0] FCQ_T_LBA_L = 9'h006;
	localparam logic [8:0] FCQ_T_ERASED = 9'h013;
	localparam logic [8:0] FCQ_T_WC_H = 9'h018;
	localparam logic [8:0] FCQ_T_WC_M = 9'h019;
	localparam logic [8:0] FCQ_T_WC_L = 9'h01A;
	localparam logic [8:0] FCQ_T_LAST = 9'h1FF;

	typedef enum logic [2:0] {
		FCQ_IDLE = 3'b001,
		FCQ_LOOK = 3'b010,
		FCQ_XFER = 3'b100
	} fcq_fsm_t;

	// Sector lookup request toward the media core
	typedef struct packed {
		logic req;
		logic linear;
		logic [3:0] head;
		logic [7:0] cyl_h;
		logic [7:0] cyl_l;
		logic [7:0] sec;
	} fcq_lkp_req_t;

	// Answer from the media core
	typedef struct packed {
		logic ack;
		logic fail;
		logic erased;
		logic [23:0] wcount;
	} fcq_lkp_ans_t;

	typedef struct packed {
		fcq_fsm_t fsm;
		logic [7:0] err;
		logic [7:0] cnt;
		logic [7:0] sec;
		logic [7:0] cyl_l;
		logic [7:0] cyl_h;
		logic [7:0] dh;
		logic [7:0] param;
		logic busy;
		logic ready;
		logic fault;
		logic drq;
		logic errs;
		logic [8:0] idx;
		logic erased;
		logic [23:0] wcount;
		logic [7:0] last_ext;
		logic [1:0] irq_st;
		logic [1:0] irq_mk;
		logic ctrl_en;
		logic lkp_req;
		logic [31:0] rdata;
		logic hready;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic irq;
		logic flt_s1;
		logic flt_s2;
	} fcq_state_t;

endpackage : fcq_pkg

// File: rtl/fcq_info_table.sv
// Byte selector for the 512-byte sector information table.
// Assumes the caller holds all fields stable during the transfer.
`timescale 1ns/100ps
module fcq_info_table
	import fcq_pkg::*;
(
	input wire logic [8:0] idx, // Byte index in table
	input wire logic linear, // Linear addressing used
	input wire logic [3:0] head, // Head or top address nibble
	input wire logic [7:0] sec, // Sector position byte
	input wire logic [7:0] cyl_l, // Track index low byte
	input wire logic [7:0] cyl_h, // Track index high byte
	input wire logic erased, // Sector erased
	input wire logic [23:0] wcount, // Write-cycle count
	output logic [7:0] tbl_byte // Selected table byte
);
	logic [7:0] g_mask;
	logic [7:0] l_mask;

	// Fields of the unused addressing form read as zero
	assign l_mask = {8{linear}}; // RULE18
	assign g_mask = ~l_mask;

	always_comb begin
		if (idx == FCQ_T_CYL_H) begin
			tbl_byte = cyl_h & g_mask; // RULE15
		end else if (idx == FCQ_T_CYL_L) begin
			tbl_byte = cyl_l & g_mask; // RULE15
		end else if (idx == FCQ_T_HEAD) begin
			tbl_byte = {4'h0, head} & g_mask; // RULE15
		end else if (idx == FCQ_T_SEC) begin
			tbl_byte = sec & g_mask; // RULE15
		end else if (idx == FCQ_T_LBA_H) begin
			tbl_byte = cyl_h & l_mask; // RULE15
		end else if (idx == FCQ_T_LBA_M) begin
			tbl_byte = cyl_l & l_mask; // RULE15
		end else if (idx == FCQ_T_LBA_L) begin
			tbl_byte = sec & l_mask; // RULE15
		end else if (idx == FCQ_T_ERASED) begin
			tbl_byte = erased ? FCQ_ERASED_VAL : 8'h00; // RULE16
		end else if (idx == FCQ_T_WC_H) begin
			tbl_byte = wcount[23:16]; // RULE17
		end else if (idx == FCQ_T_WC_M) begin
			tbl_byte = wcount[15:8]; // RULE17
		end else if (idx == FCQ_T_WC_L) begin
			tbl_byte = wcount[7:0]; // RULE17
		end else begin
			tbl_byte = 8'h00; // RULE18
		end
	end

endmodule : fcq_info_table

// File: rtl/fcq_query.sv
// Device-side interpreter of the detailed-error and sector-information
// queries, with its task-file registers behind an AHB-Lite slave.
// Assumes one clock, a single master, word transfers only.
//
// How it works
// RULE1: Unsupported query sets the aborted bit, bit 2 of error register.
// RULE2: Failed sector lookup may abort the query; here it does.
// RULE3: Error completion clears busy, sets ready, error summary if error nonzero.
// RULE4: Error completion copies the device fault into status bit 5.
// RULE5: Successful completion clears busy, sets ready, clears error summary.
// RULE6: Host issues queries only while ready is one and busy zero.
// RULE7: Error query reports the previous command's cause, or no-error code.
// RULE8: Detailed code is one byte in error register; 00h means none.
// RULE9: Error query is code 03h and has no data phase.
// RULE10: Code 87h is the sector-information query when the feature is on.
// RULE11: Sector query moves its table device to host by programmed I/O.
// RULE12: Host sets drive/head bit 6 for linear, low nibble top address.
// RULE13: Host puts address in sector, track low and track high registers.
// RULE14: Successful sector query delivers 512 bytes through the data port.
// RULE15: Table holds geometric address at 00h-03h, linear at 04h-06h.
// RULE16: Table byte 13h is FFh when erased, 00h otherwise.
// RULE17: Table bytes 18h-1Ah hold write-cycle count, high byte first.
// RULE18: Unsupported or unused table fields read as zero.
`timescale 1ns/100ps
module fcq_query
	import fcq_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic reset_n, // Async reset
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response
	output logic irq, // Interrupt level
	output fcq_lkp_req_t lkp, // Lookup request
	input wire fcq_lkp_ans_t lkp_ans, // Lookup answer
	input wire logic dev_fault // Fault pin, async
);
	fcq_state_t s;
	fcq_state_t n;
	logic [7:0] tbl_byte;
	logic ev_done;
	logic ev_drq;
	logic [1:0] irq_clr;
	logic rd_go;
	logic [7:0] wbyte;

	// ----------------------------------------------------------------
	// Table byte for the current data-port index
	// ----------------------------------------------------------------
	fcq_info_table u_tbl (
		.idx(s.idx),
		.linear(s.dh[FCQ_DH_LIN]),
		.head(s.dh[3:0]),
		.sec(s.sec),
		.cyl_l(s.cyl_l),
		.cyl_h(s.cyl_h),
		.erased(s.erased),
		.wcount(s.wcount),
		.tbl_byte(tbl_byte)
	);

	// Error completion with a given cause code
	function automatic fcq_state_t abort_fn(fcq_state_t x, logic [7:0] code);
		fcq_state_t y;
		y = x;
		y.err = FCQ_COMMAND_ABORTED_BIT_VAL; // RULE1
		y.errs = 1'b1; // RULE3
		y.fault = x.flt_s2; // RULE4
		y.busy = 1'b0; // RULE3
		y.ready = 1'b1; // RULE3
		y.drq = 1'b0;
		y.lkp_req = 1'b0;
		y.fsm = FCQ_IDLE;
		y.last_ext = code; // RULE7
		return y;
	endfunction : abort_fn

	assign rd_go = hsel && htrans[1] && hready && !hwrite;
	assign wbyte = hwdata[7:0];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		ev_done = 1'b0;
		ev_drq = 1'b0;
		irq_clr = 2'b00;
		n.hready = 1'b1;
		n.rdata = 32'h0000_0000;
		// Data phase of a write
		if (s.wr_pend) begin
			if (s.wr_addr == FCQ_A_CNT) begin
				n.cnt = wbyte;
			end else if (s.wr_addr == FCQ_A_SEC) begin
				n.sec = wbyte; // RULE13
			end else if (s.wr_addr == FCQ_A_CYL_L) begin
				n.cyl_l = wbyte; // RULE13
			end else if (s.wr_addr == FCQ_A_CYL_H) begin
				n.cyl_h = wbyte; // RULE13
			end else if (s.wr_addr == FCQ_A_DH) begin
				n.dh = wbyte; // RULE12
			end else if (s.wr_addr == FCQ_A_PARAM) begin
				n.param = wbyte;
			end else if (s.wr_addr == FCQ_A_IRQ_ST) begin
				irq_clr = hwdata[1:0];
			end else if (s.wr_addr == FCQ_A_IRQ_MK) begin
				n.irq_mk = hwdata[1:0];
			end else if (s.wr_addr == FCQ_A_CTRL) begin
				n.ctrl_en = hwdata[FCQ_CTRL_EN];
			end else if (s.wr_addr == FCQ_A_CMD && s.fsm == FCQ_IDLE) begin
				// Commands while busy or transferring are dropped
				if (s.ctrl_en && wbyte == FCQ_CMD_ERRQ) begin
					n.err = s.last_ext; // RULE7 RULE8 RULE9
					n.last_ext = FCQ_EXT_NONE;
					n.errs = 1'b0; // RULE5
					n.fault = 1'b0;
					n.busy = 1'b0; // RULE5
					n.ready = 1'b1; // RULE5
					ev_done = 1'b1;
				end else if (s.ctrl_en && wbyte == FCQ_CMD_SECQ) begin
					n.busy = 1'b1; // RULE10
					n.errs = 1'b0;
					n.err = 8'h00;
					n.fault = 1'b0;
					n.lkp_req = 1'b1;
					n.fsm = FCQ_LOOK;
				end else begin
					n = abort_fn(n, FCQ_EXT_BADCMD); // RULE1
					ev_done = 1'b1;
				end
			end
		end
		n.wr_pend = hsel && htrans[1] && hready && hwrite;
		n.wr_addr = haddr[7:0];
		// Sector lookup handshake
		if (s.fsm == FCQ_LOOK && lkp_ans.ack) begin
			if (lkp_ans.fail) begin
				n = abort_fn(n, FCQ_EXT_BADADDR); // RULE2
				ev_done = 1'b1;
			end else begin
				n.lkp_req = 1'b0;
				n.erased = lkp_ans.erased;
				n.wcount = lkp_ans.wcount;
				n.idx = 9'h000;
				n.drq = 1'b1; // RULE11
				n.busy = 1'b0;
				n.fsm = FCQ_XFER;
				ev_drq = 1'b1;
			end
		end
		// Address phase of a read; data port pops one byte
		if (rd_go) begin
			if (haddr[7:0] == FCQ_A_DATA) begin
				if (s.fsm == FCQ_XFER) begin
					n.rdata = {24'h00_0000, tbl_byte}; // RULE11
					n.idx = s.idx + 9'h001;
					if (s.idx == FCQ_T_LAST) begin
						n.drq = 1'b0; // RULE14
						n.busy = 1'b0; // RULE5
						n.ready = 1'b1; // RULE5
						n.errs = 1'b0; // RULE5
						n.last_ext = FCQ_EXT_NONE; // RULE7
						n.fsm = FCQ_IDLE;
						ev_done = 1'b1;
					end
				end
			end else if (haddr[7:0] == FCQ_A_ERR) begin
				n.rdata = {24'h00_0000, s.err}; // RULE8
			end else if (haddr[7:0] == FCQ_A_CNT) begin
				n.rdata = {24'h00_0000, s.cnt};
			end else if (haddr[7:0] == FCQ_A_SEC) begin
				n.rdata = {24'h00_0000, s.sec};
			end else if (haddr[7:0] == FCQ_A_CYL_L) begin
				n.rdata = {24'h00_0000, s.cyl_l};
			end else if (haddr[7:0] == FCQ_A_CYL_H) begin
				n.rdata = {24'h00_0000, s.cyl_h};
			end else if (haddr[7:0] == FCQ_A_DH) begin
				n.rdata = {24'h00_0000, s.dh};
			end else if (haddr[7:0] == FCQ_A_STAT) begin
				n.rdata = {24'h00_0000, s.busy, s.ready, s.fault, 1'b0,
					s.drq, 2'b00, s.errs};
			end else if (haddr[7:0] == FCQ_A_IRQ_ST) begin
				n.rdata = {30'h0000_0000, s.irq_st};
			end else if (haddr[7:0] == FCQ_A_IRQ_MK) begin
				n.rdata = {30'h0000_0000, s.irq_mk};
			end else if (haddr[7:0] == FCQ_A_CTRL) begin
				n.rdata = {31'h0000_0000, s.ctrl_en};
			end
		end
		// Synchroniser last, so aborts above see only the second stage
		n.flt_s1 = dev_fault;
		n.flt_s2 = s.flt_s1;
		// Set wins over a clear in the same cycle
		n.irq_st = (s.irq_st & ~irq_clr) | {ev_drq, ev_done};
		n.irq = |(n.irq_st & n.irq_mk);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.fsm <= FCQ_IDLE;
			s.ready <= 1'b1;
			s.hready <= 1'b1;
			s.ctrl_en <= FCQ_CTRL_EN_RST;
		end else begin
			s <= n;
		end
	end

	assign hrdata = s.rdata;
	assign hreadyout = s.hready;
	assign hresp = 1'b0;
	assign irq = s.irq;
	assign lkp = {s.lkp_req, s.dh[FCQ_DH_LIN], s.dh[3:0], s.cyl_h, s.cyl_l, s.sec};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic cmd_wr;
	logic [7:0] prev_ext;
	assign cmd_wr = s.wr_pend && s.wr_addr == FCQ_A_CMD && s.fsm == FCQ_IDLE;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_ext <= 8'h00;
		end else begin
			prev_ext <= s.last_ext;
		end
	end

	bad_cmd_abort_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE1
		cmd_wr && (!s.ctrl_en || (wbyte != FCQ_CMD_ERRQ && wbyte != FCQ_CMD_SECQ))
		|=> s.err[FCQ_ERR_COMMAND_ABORTED_BIT] && s.errs && !s.busy && s.ready)
		else $error("unsupported command not aborted");

	lookup_fail_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE2
		s.fsm == FCQ_LOOK && lkp_ans.ack && lkp_ans.fail
		|=> s.err[FCQ_ERR_COMMAND_ABORTED_BIT] && s.fsm == FCQ_IDLE && s.last_ext == FCQ_EXT_BADADDR)
		else $error("failed lookup not aborted");

	err_summary_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE3
		s.errs |-> s.err != 8'h00 && !s.busy && s.ready)
		else $error("error summary without error bits");

	fault_copy_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE4
		cmd_wr && (!s.ctrl_en || (wbyte != FCQ_CMD_ERRQ && wbyte != FCQ_CMD_SECQ))
		|=> s.fault == $past(s.flt_s2))
		else $error("fault flag not reported");

	ext_report_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE7
		cmd_wr && s.ctrl_en && wbyte == FCQ_CMD_ERRQ
		|=> s.err == prev_ext && !s.errs && !s.busy ##1 s.last_ext == FCQ_EXT_NONE)
		else $error("detailed code not reported");

	query_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE10
		cmd_wr && s.ctrl_en && wbyte == FCQ_CMD_SECQ
		|=> s.busy && lkp.req && s.fsm == FCQ_LOOK)
		else $error("sector query not started");

	lookup_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE10
		s.fsm == FCQ_LOOK && !lkp_ans.ack |=> s.fsm == FCQ_LOOK && lkp.req && s.busy)
		else $error("lookup request dropped early");

	drq_raise_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE11
		s.fsm == FCQ_LOOK && lkp_ans.ack && !lkp_ans.fail
		|=> s.drq && !s.busy && s.fsm == FCQ_XFER && !lkp.req)
		else $error("data request not raised");

	fail_release_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE3
		s.fsm == FCQ_LOOK && lkp_ans.ack && lkp_ans.fail
		|=> !s.busy && s.ready && s.errs && !s.drq && !lkp.req)
		else $error("failed lookup status wrong");

	errq_no_data_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE9
		cmd_wr && s.ctrl_en && wbyte == FCQ_CMD_ERRQ |=> !s.drq && s.fsm == FCQ_IDLE)
		else $error("error query opened a data phase");

	query_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE5
		s.fsm == FCQ_XFER && rd_go && haddr[7:0] == FCQ_A_DATA && s.idx == FCQ_T_LAST
		|=> !s.busy && s.ready && !s.errs && !s.drq && s.last_ext == FCQ_EXT_NONE)
		else $error("sector query not completed");

	xfer_len_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE14
		s.fsm == FCQ_XFER ##1 s.fsm == FCQ_IDLE
		|-> $past(s.idx) == FCQ_T_LAST && !s.drq && !s.errs && s.ready)
		else $error("transfer ended early");

	// ----------------------------------------------------------------
	// Table byte checks
	// ----------------------------------------------------------------

	erased_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE16
		s.idx == FCQ_T_ERASED |-> tbl_byte == (s.erased ? FCQ_ERASED_VAL : 8'h00))
		else $error("erased flag byte wrong");

	wcount_msb_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE17
		s.idx == FCQ_T_WC_H |-> tbl_byte == s.wcount[23:16])
		else $error("write count high byte wrong");

	wcount_lsb_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE17
		s.idx == FCQ_T_WC_L |-> tbl_byte == s.wcount[7:0])
		else $error("write count low byte wrong");

	geo_cyl_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE15
		s.idx == FCQ_T_CYL_H |-> tbl_byte == (s.dh[FCQ_DH_LIN] ? 8'h00 : s.cyl_h))
		else $error("track high byte wrong");

	geo_head_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE15
		s.idx == FCQ_T_HEAD |-> tbl_byte == (s.dh[FCQ_DH_LIN] ? 8'h00 : {4'h0, s.dh[3:0]}))
		else $error("head byte wrong");

	geo_sector_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE15
		s.idx == FCQ_T_SEC |-> tbl_byte == (s.dh[FCQ_DH_LIN] ? 8'h00 : s.sec))
		else $error("sector byte wrong");

	lin_high_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE15
		s.idx == FCQ_T_LBA_H |-> tbl_byte == (s.dh[FCQ_DH_LIN] ? s.cyl_h : 8'h00))
		else $error("linear high byte wrong");

	lin_low_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE15
		s.idx == FCQ_T_LBA_L |-> tbl_byte == (s.dh[FCQ_DH_LIN] ? s.sec : 8'h00))
		else $error("linear low byte wrong");

	reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE18
		(s.idx > FCQ_T_WC_L || (s.idx > FCQ_T_LBA_L && s.idx < FCQ_T_ERASED)
		|| (s.idx > FCQ_T_ERASED && s.idx < FCQ_T_WC_H)) |-> tbl_byte == 8'h00)
		else $error("reserved table byte not zero");

endmodule : fcq_query

// File: tb/fcq_media_model.sv
// Media core model that answers sector lookups of the query block.
// Assumes one clock; answer delay and outcome are set by the bench.
`timescale 1ns/100ps
module fcq_media_model
	import fcq_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire logic reset_n, // Async reset
	input wire fcq_lkp_req_t lkp, // Lookup request
	output fcq_lkp_ans_t lkp_ans, // Lookup answer
	input wire logic [7:0] delay, // Cycles before ack
	input wire logic fail, // Answer with failure
	input wire logic erased, // Erased flag to report
	input wire logic [23:0] wcount // Write count to report
);
	// ----------------------------------------------------------------
	// Answer timing
	// ----------------------------------------------------------------
	logic [7:0] cnt_r;
	logic done_r;
	logic ack_r;
	// One ack per request; a held request is not answered twice
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 8'h00;
			done_r <= 1'b0;
			ack_r <= 1'b0;
		end else begin
			ack_r <= 1'b0;
			if (!lkp.req) begin
				cnt_r <= 8'h00;
				done_r <= 1'b0;
			end else if (!done_r) begin
				if (cnt_r == delay) begin
					ack_r <= 1'b1;
					done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end
	// Fields are garbage outside the ack cycle
	assign lkp_ans = ack_r ? {1'b1, fail, erased, wcount} : {1'b0, ~fail, ~erased, ~wcount};
endmodule : fcq_media_model

// File: tb/fcq_query_bench.sv
// Self-checking bench of the query block, acting as AHB-Lite master.
// Assumes the media model answers lookups; hready loops back.
`timescale 1ns/100ps
module fcq_query_bench;
	import fcq_pkg::*;
	logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, irq, dev_fault;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	fcq_lkp_req_t lkp;
	fcq_lkp_ans_t lkp_ans;
	logic m_fail, m_erased;
	logic [7:0] m_delay;
	logic [23:0] m_wcount;
	int err_total, checks_done;

	fcq_query dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq(irq), .lkp(lkp), .lkp_ans(lkp_ans), .dev_fault(dev_fault));
	fcq_media_model media (.sys_clk(sys_clk), .reset_n(reset_n), .lkp(lkp),
		.lkp_ans(lkp_ans), .delay(m_delay), .fail(m_fail), .erased(m_erased),
		.wcount(m_wcount));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Entered just after a rising edge; pre-edge values sampled
	task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask : bus

	task automatic rdc(string what, logic [7:0] a, logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk(what, rd, exp);
	endtask : rdc

	// Polls status until busy drops, bounded
	task automatic settle;
		int n;
		n = 0;
		bus(1'b0, FCQ_A_STAT, 32'h00000000);
		while (rd[FCQ_ST_BUSY] !== 1'b0 && n < 100) begin
			bus(1'b0, FCQ_A_STAT, 32'h00000000);
			n++;
		end
		chk("busy timeout", rd[FCQ_ST_BUSY], 32'h0);
	endtask : settle

	function automatic logic [7:0] exp_byte(int i, logic lin, logic [3:0] hd,
		logic [7:0] s, logic [7:0] cl, logic [7:0] ch, logic er, logic [23:0] wc);
		case (i)
			0: return lin ? 8'h00 : ch;
			1: return lin ? 8'h00 : cl;
			2: return lin ? 8'h00 : {4'h0, hd};
			3: return lin ? 8'h00 : s;
			4: return lin ? ch : 8'h00;
			5: return lin ? cl : 8'h00;
			6: return lin ? s : 8'h00;
			19: return er ? 8'hFF : 8'h00;
			24: return wc[23:16];
			25: return wc[15:8];
			26: return wc[7:0];
			default: return 8'h00;
		endcase
	endfunction : exp_byte

	task automatic sec_query(logic lin, logic [3:0] hd, logic [7:0] s, logic [7:0] cl,
		logic [7:0] ch, logic er, logic [23:0] wc, logic fl, logic [7:0] dl);
		m_fail <= fl;
		m_erased <= er;
		m_wcount <= wc;
		m_delay <= dl;
		bus(1'b1, FCQ_A_DH, {24'h0, 1'b1, lin, 2'b10, hd});
		bus(1'b1, FCQ_A_SEC, {24'h0, s});
		bus(1'b1, FCQ_A_CYL_L, {24'h0, cl});
		bus(1'b1, FCQ_A_CYL_H, {24'h0, ch});
		bus(1'b1, FCQ_A_CMD, {24'h0, FCQ_CMD_SECQ});
		if (dl > 8'h08) begin
			rdc("busy status", FCQ_A_STAT, 32'hC0);
			chk("lookup request", lkp, {1'b1, lin, hd, ch, cl, s});
		end
		settle();
		if (fl) begin
			chk("abort status", rd, 32'h41);
			rdc("abort error", FCQ_A_ERR, 32'h04);
		end else begin
			chk("drq status", rd, 32'h48);
			for (int i = 0; i < 512; i++) begin
				rdc("table byte", FCQ_A_DATA, exp_byte(i, lin, hd, s, cl, ch, er, wc));
			end
			rdc("end status", FCQ_A_STAT, 32'h40);
		end
	endtask : sec_query

	task automatic wrap_up;
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{hsel, hwrite, dev_fault, m_fail, m_erased, reset_n} = 6'h00;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		m_delay = 8'h00;
		m_wcount = 24'h0;
		err_total = 0;
		checks_done = 0;
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rdc("reset status", FCQ_A_STAT, 32'h40);
		rdc("reset ctrl", FCQ_A_CTRL, 32'h01);
		rdc("reset mask", FCQ_A_IRQ_MK, 32'h00);
		rdc("unmapped", 8'h3C, 32'h00);
		bus(1'b1, FCQ_A_CNT, 32'h5A);
		rdc("count reg", FCQ_A_CNT, 32'h5A);
		bus(1'b1, FCQ_A_PARAM, 32'h33);
		rdc("param reads zero", FCQ_A_PARAM, 32'h00);
		// Bad codes, without and with device fault
		for (int k = 0; k < 2; k++) begin
			dev_fault <= k[0];
			repeat (3) @(posedge sys_clk);
			bus(1'b1, FCQ_A_CMD, k ? 32'hC4 : 32'h55);
			rdc("abort bit", FCQ_A_ERR, 32'h04);
			rdc("error status", FCQ_A_STAT, k ? 32'h61 : 32'h41);
			bus(1'b1, FCQ_A_CMD, {24'h0, FCQ_CMD_ERRQ});
			rdc("cause code", FCQ_A_ERR, 32'h20);
			rdc("query status", FCQ_A_STAT, 32'h40);
		end
		dev_fault <= 1'b0;
		bus(1'b1, FCQ_A_CMD, {24'h0, FCQ_CMD_ERRQ});
		rdc("no error code", FCQ_A_ERR, 32'h00);
		chk("irq masked", irq, 1'b0);
		bus(1'b1, FCQ_A_IRQ_MK, 32'h01);
		bus(1'b0, FCQ_A_STAT, 32'h0);
		chk("irq raised", irq, 1'b1);
		bus(1'b1, FCQ_A_IRQ_ST, 32'h01);
		rdc("irq cleared", FCQ_A_IRQ_ST, 32'h00);
		chk("irq low", irq, 1'b0);
		// Feature disabled turns the sector query into a bad code
		bus(1'b1, FCQ_A_CTRL, 32'h00);
		bus(1'b1, FCQ_A_CMD, {24'h0, FCQ_CMD_SECQ});
		rdc("disabled abort", FCQ_A_ERR, 32'h04);
		bus(1'b1, FCQ_A_CTRL, 32'h01);
		sec_query(1'b0, 4'h3, 8'h56, 8'h34, 8'h12, 1'b1, 24'hABCDEF, 1'b0, 8'd20);
		rdc("irq both", FCQ_A_IRQ_ST, 32'h03);
		chk("irq after table", irq, 1'b1);
		bus(1'b1, FCQ_A_IRQ_ST, 32'h03);
		sec_query(1'b1, 4'h9, 8'h01, 8'h80, 8'hFE, 1'b0, 24'h000102, 1'b0, 8'd0);
		sec_query(1'b0, 4'h1, 8'h02, 8'h03, 8'h04, 1'b0, 24'h0, 1'b1, 8'd3);
		bus(1'b1, FCQ_A_CMD, {24'h0, FCQ_CMD_ERRQ});
		rdc("address cause", FCQ_A_ERR, 32'h21);
		rdc("idle data port", FCQ_A_DATA, 32'h00);
		rdc("sector reg", FCQ_A_SEC, 32'h02);
		rdc("track low reg", FCQ_A_CYL_L, 32'h03);
		rdc("track high reg", FCQ_A_CYL_H, 32'h04);
		rdc("drive head reg", FCQ_A_DH, 32'hA1);
		chk("okay response", hresp, 32'h0);
		wrap_up();
	end

	initial begin
		#400000;
		err_total++;
		wrap_up();
	end
endmodule : fcq_query_bench
